/* File: hdl/mfio_map.vh */
// register offsets, field positions, reset values and timing for the slot mux
`ifndef MFIO_MAP_VH
`define MFIO_MAP_VH

// -----------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------
`define MFIO_REG_SLOTCFG 8'h00
`define MFIO_REG_OUTSET 8'h04
`define MFIO_REG_PWMDUTY3 8'h08
`define MFIO_REG_PWMDUTY4 8'h0C
`define MFIO_REG_FILTSTD 8'h10
`define MFIO_REG_FILTEXT 8'h14
`define MFIO_REG_CYCLE 8'h18
`define MFIO_REG_INSTATE 8'h1C
`define MFIO_REG_COUNT 8'h20
`define MFIO_REG_LATCH 8'h24
`define MFIO_REG_ANALOG 8'h28
`define MFIO_REG_IRQSTAT 8'h2C
`define MFIO_REG_IRQMASK 8'h30

// -----------------------------------------------------------------------
// slot configuration fields
// -----------------------------------------------------------------------
`define MFIO_S1_LSB 0
`define MFIO_S2_LSB 2
`define MFIO_S4_LSB 4
`define MFIO_S1_NONE 2'h0
`define MFIO_S1_ENC 2'h1
`define MFIO_S1_CNT 2'h2
`define MFIO_S1_DIO 2'h3
`define MFIO_S2_NONE 2'h0
`define MFIO_S2_DIO 2'h1
`define MFIO_S2_PWM 2'h2
`define MFIO_S4_NONE 2'h0
`define MFIO_S4_ANA 2'h1
`define MFIO_S4_DIN 2'h2
`define MFIO_SLOTCFG_RST 6'h00

// -----------------------------------------------------------------------
// irq status bits
// -----------------------------------------------------------------------
`define MFIO_IRQ_WDOG 0
`define MFIO_IRQ_LATCH 1
`define MFIO_IRQ_INCHG 2

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define MFIO_CLK_HZ 125000000
`define MFIO_WDOG_MS 100
`define MFIO_WDOG_CYC ((`MFIO_CLK_HZ / 1000) * `MFIO_WDOG_MS)
`define MFIO_TICK_US 10
`define MFIO_TICK_CYC ((`MFIO_CLK_HZ / 1000000) * `MFIO_TICK_US)
`define MFIO_FILT_DEF_US 3000
`define MFIO_FILT_DEF (`MFIO_FILT_DEF_US / `MFIO_TICK_US)
`define MFIO_FILT_MIN 16'h0001
`define MFIO_DUTY_OFF 16'h0000
`define MFIO_DUTY_ON 16'hFFFF

`endif

/* File: hdl/mfio_in_filter.v */
// one input channel: three-flop synchroniser and tick-based debounce
`timescale 1ns/1ps
module mfio_in_filter
#(
    parameter WIDTH = 16
)
(
    input wire clk,
    input wire reset,
    input wire tick,
    input wire [WIDTH-1:0] filtTicks,
    input wire pinIn,
    output reg filtOut
)
;
    reg sync1_q;
    reg sync2_q;
    reg sync3_q;
    reg [WIDTH-1:0] stable_q;

    always @(posedge clk)
    begin
        if (reset)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            stable_q <= {WIDTH{1'b0}};
            filtOut <= 1'b0;
        end
        else
        begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            // a level differing from output must survive filtTicks ticks
            if (sync2_q != sync3_q || sync3_q == filtOut)
                stable_q <= {WIDTH{1'b0}};
            else if (tick)
            begin
                if (stable_q + 1'b1 >= filtTicks)
                begin
                    filtOut <= sync3_q;
                    stable_q <= {WIDTH{1'b0}};
                end
                else
                    stable_q <= stable_q + 1'b1;
            end
        end
    end
endmodule // mfio_in_filter

/* File: hdl/mfio_slot_mux.v */
// multifunction i/o slot mux with axi4-lite registers
// Notes on behaviour
// - four slots, each one module at most, module picks pin modes
// - fixed 100 ms watchdog; host must write cycle register sooner
// - slot 1 uses inputs 1,2, maybe 3, outputs 1,2: enc, cnt, dio
// - encoder mode: two encoder inputs up to 250 kHz, two outputs; code passes each through the tick filter, one edge per 10 us at most
// - counter mode: count input, direction input, two counter outputs
// - input 3 in slot 1 only for encoder; high latches the value
// - slot 2 uses inputs 3,4, outputs 3,4: plain dio or pwm
// - slot 3 has inputs 5,6 as fixed filtered plain inputs
// - slot 4 inputs 7,8: analog 12-bit or filtered plain inputs
// - all eight inputs filtered, default 3 ms, minimum 10 us
// - extra filter time settable only for inputs 3 to 6
// - status led per input shows its current logic state
// - pwm duty 0000 drives fully low, FFFF fully high
// - four outputs, each with a status led
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "mfio_map.vh"
module mfio_slot_mux
#(
    parameter WDOG_CYCLES = `MFIO_WDOG_CYC,
    parameter NUM_IN = 8
)
(
    input wire clk,
    input wire reset,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NUM_IN-1:0] inPins,
    input wire [23:0] analogIn,
    output reg [3:0] outPins,
    output reg [NUM_IN-1:0] inLeds,
    output reg [3:0] outLeds,
    output wire irq
)
;
    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    reg [5:0] slotCfg_q;
    reg [3:0] outSet_q;
    reg [15:0] duty3_q;
    reg [15:0] duty4_q;
    reg [15:0] filtStd_q;
    reg [15:0] filtExt_q;
    reg [31:0] count_q;
    reg [31:0] latch_q;
    reg [2:0] irqStat_q;
    reg [2:0] irqMask_q;
    reg [31:0] wdog_q;
    reg wdogExp_q;
    reg [15:0] tickCnt_q;
    reg tick_q;
    reg [15:0] pwmCnt_q;
    reg [NUM_IN-1:0] filtPrev_q;
    reg awHeld_q;
    reg wHeld_q;
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg [1:0] cntPrev_q;
    reg encLatchPrev_q;
    localparam [15:0] FILT_DEF = `MFIO_FILT_DEF;
    wire [NUM_IN-1:0] filt;
    wire [1:0] s1Mode = slotCfg_q[`MFIO_S1_LSB +: 2];
    wire [1:0] s2Mode = slotCfg_q[`MFIO_S2_LSB +: 2];
    wire [1:0] s4Mode = slotCfg_q[`MFIO_S4_LSB +: 2];
    wire wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    wire cycleWrite = wrFire && awAddr_q == `MFIO_REG_CYCLE;

    // -------------------------------------------------------------------
    // filter tick and per-input filters
    // -------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (reset || tickCnt_q == `MFIO_TICK_CYC - 1)
            tickCnt_q <= 16'h0000;
        else
            tickCnt_q <= tickCnt_q + 16'h0001;
        tick_q <= !reset && tickCnt_q == `MFIO_TICK_CYC - 1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi = gi + 1)
        begin : gIn
            // only inputs 3..6 (index 2..5) take the extra setting
            wire useExt = (gi >= 2) && (gi <= 5);
            wire [15:0] ticks = useExt ? filtExt_q : filtStd_q;
            mfio_in_filter #(.WIDTH(16)) uFilt (.clk(clk), .reset(reset),
                .tick(tick_q), .filtTicks(ticks), .pinIn(inPins[gi]),
                .filtOut(filt[gi]));
        end
    endgenerate

    // -------------------------------------------------------------------
    // watchdog
    // -------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (reset)
        begin
            wdog_q <= 32'h00000000;
            wdogExp_q <= 1'b1; // outputs off until the host's first kick
        end
        else if (cycleWrite)
        begin
            wdog_q <= 32'h00000000;
            wdogExp_q <= 1'b0;
        end
        else if (wdog_q >= WDOG_CYCLES - 1)
            wdogExp_q <= 1'b1;
        else
            wdog_q <= wdog_q + 32'h00000001;
    end

    // -------------------------------------------------------------------
    // slot 1 counter / encoder
    // -------------------------------------------------------------------
    // x1 counting on the filtered count edge; decode kept small
    wire cntRise = filt[0] && !cntPrev_q[0];
    wire encA = filt[0];
    wire encB = filt[1];
    wire encStep = (encA != cntPrev_q[0]) || (encB != cntPrev_q[1]);
    wire encUp = encA ^ cntPrev_q[1];
    wire latchIn = (s1Mode == `MFIO_S1_ENC) && filt[2];
    wire latchEv = latchIn && !encLatchPrev_q;

    always @(posedge clk)
    begin
        if (reset)
        begin
            count_q <= 32'h00000000;
            latch_q <= 32'h00000000;
            cntPrev_q <= 2'h0;
            encLatchPrev_q <= 1'b0;
        end
        else
        begin
            cntPrev_q <= filt[1:0];
            encLatchPrev_q <= latchIn;
            if (latchEv)
                latch_q <= count_q;
            if (wrFire && awAddr_q == `MFIO_REG_COUNT)
                count_q <= wData_q;
            else if (s1Mode == `MFIO_S1_CNT && cntRise)
                count_q <= filt[1] ? count_q + 32'h00000001
                                   : count_q - 32'h00000001;
            else if (s1Mode == `MFIO_S1_ENC && encStep)
                count_q <= encUp ? count_q + 32'h00000001
                                 : count_q - 32'h00000001;
        end
    end

    // -------------------------------------------------------------------
    // pwm for outputs 3 and 4
    // -------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (reset)
            pwmCnt_q <= 16'h0000;
        else
            pwmCnt_q <= pwmCnt_q + 16'h0001;
    end

    // 0xFFFF compare forces full on; 0x0000 never exceeds count
    wire pwm3 = (duty3_q == `MFIO_DUTY_ON) || (pwmCnt_q < duty3_q);
    wire pwm4 = (duty4_q == `MFIO_DUTY_ON) || (pwmCnt_q < duty4_q);

    // -------------------------------------------------------------------
    // output and led routing
    // -------------------------------------------------------------------
    reg [3:0] outMux;
    always @*
    begin
        outMux = 4'h0;
        case (s1Mode)
            `MFIO_S1_ENC: outMux[1:0] = outSet_q[1:0];
            `MFIO_S1_CNT: outMux[1:0] = outSet_q[1:0];
            `MFIO_S1_DIO: outMux[1:0] = outSet_q[1:0];
            default: outMux[1:0] = 2'h0;
        endcase
        case (s2Mode)
            `MFIO_S2_DIO: outMux[3:2] = outSet_q[3:2];
            `MFIO_S2_PWM: outMux[3:2] = {pwm4, pwm3};
            default: outMux[3:2] = 2'h0;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            outPins <= 4'h0;
            outLeds <= 4'h0;
            inLeds <= {NUM_IN{1'b0}};
            filtPrev_q <= {NUM_IN{1'b0}};
        end
        else
        begin
            outPins <= wdogExp_q ? 4'h0 : outMux;
            outLeds <= wdogExp_q ? 4'h0 : outMux;
            inLeds <= filt;
            filtPrev_q <= filt;
        end
    end

    // -------------------------------------------------------------------
    // interrupts
    // -------------------------------------------------------------------
    wire [2:0] irqEv;
    assign irqEv[`MFIO_IRQ_WDOG] = (wdog_q >= WDOG_CYCLES - 1) && !wdogExp_q
                                   && !cycleWrite;
    assign irqEv[`MFIO_IRQ_LATCH] = latchEv;
    assign irqEv[`MFIO_IRQ_INCHG] = |(filt ^ filtPrev_q);
    assign irq = |(irqStat_q & irqMask_q);

    // -------------------------------------------------------------------
    // axi4-lite write path
    // -------------------------------------------------------------------
    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;

    function [15:0] clampFilt;
        input [15:0] v;
        begin
            // below 10 us is not allowed
            clampFilt = (v < `MFIO_FILT_MIN) ? `MFIO_FILT_MIN : v;
        end
    endfunction

    always @(posedge clk)
    begin
        if (reset)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            slotCfg_q <= `MFIO_SLOTCFG_RST;
            outSet_q <= 4'h0;
            duty3_q <= `MFIO_DUTY_OFF;
            duty4_q <= `MFIO_DUTY_OFF;
            filtStd_q <= FILT_DEF;
            filtExt_q <= FILT_DEF;
            irqStat_q <= 3'h0;
            irqMask_q <= 3'h0;
        end
        else
        begin
            if (s_axi_awvalid && !awHeld_q)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !wHeld_q)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // event set wins over a write-one clear
            irqStat_q <= irqStat_q | irqEv;
            if (wrFire)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (awAddr_q)
                    `MFIO_REG_SLOTCFG:
                        if (wStrb_q[0])
                            slotCfg_q <= wData_q[5:0];
                    `MFIO_REG_OUTSET:
                        if (wStrb_q[0])
                            outSet_q <= wData_q[3:0];
                    `MFIO_REG_PWMDUTY3:
                        duty3_q <= wData_q[15:0];
                    `MFIO_REG_PWMDUTY4:
                        duty4_q <= wData_q[15:0];
                    `MFIO_REG_FILTSTD:
                        filtStd_q <= clampFilt(wData_q[15:0]);
                    `MFIO_REG_FILTEXT:
                        filtExt_q <= clampFilt(wData_q[15:0]);
                    `MFIO_REG_IRQSTAT:
                        irqStat_q <= (irqStat_q & ~wData_q[2:0]) | irqEv;
                    `MFIO_REG_IRQMASK:
                        irqMask_q <= wData_q[2:0];
                    `MFIO_REG_CYCLE, `MFIO_REG_COUNT: ;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // axi4-lite read path
    // -------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // slot 4 analog result only in analog mode, 12 bits each channel
    wire [31:0] anaWord = (s4Mode == `MFIO_S4_ANA) ?
        {4'h0, analogIn[23:12], 4'h0, analogIn[11:0]} : 32'h00000000;

    reg [31:0] rdMux;
    always @*
    begin
        case ({s_axi_araddr[7:2], 2'h0})
            `MFIO_REG_SLOTCFG: rdMux = {26'h0, slotCfg_q};
            `MFIO_REG_OUTSET: rdMux = {28'h0, outSet_q};
            `MFIO_REG_PWMDUTY3: rdMux = {16'h0, duty3_q};
            `MFIO_REG_PWMDUTY4: rdMux = {16'h0, duty4_q};
            `MFIO_REG_FILTSTD: rdMux = {16'h0, filtStd_q};
            `MFIO_REG_FILTEXT: rdMux = {16'h0, filtExt_q};
            `MFIO_REG_CYCLE: rdMux = {31'h0, wdogExp_q};
            // slot 3 inputs always plain, slot 4 filtered inputs read even in analog mode
            `MFIO_REG_INSTATE: rdMux = {24'h0, filt};
            `MFIO_REG_COUNT: rdMux = count_q;
            `MFIO_REG_LATCH: rdMux = latch_q;
            `MFIO_REG_ANALOG: rdMux = anaWord;
            `MFIO_REG_IRQSTAT: rdMux = {29'h0, irqStat_q};
            `MFIO_REG_IRQMASK: rdMux = {29'h0, irqMask_q};
            default: rdMux = 32'h00000000;
        endcase
    end

    wire rdOk = ({s_axi_araddr[7:2], 2'h0} <= `MFIO_REG_IRQMASK)
        && (s_axi_araddr[31:8] == 24'h0);
    always @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // mfio_slot_mux

/* File: test/mfio_slot_mux_properties.sv */
// port-level checker for the slot mux
`timescale 1ns/1ps
module mfio_slot_mux_properties
#(
    parameter WDOG_CYCLES = 200
)
(
    input wire clk,
    input wire reset,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] outPins,
    input wire [7:0] inLeds,
    input wire [3:0] outLeds,
    input wire irq
);
    // --------------------
    // helper logic
    // --------------------
    // full at reset: nothing may drive before the first cyclic write
    reg [15:0] idleCnt_q;
    always @(posedge clk)
    begin
        if (reset)
            idleCnt_q <= 16'hFFFF;
        else if (s_axi_awvalid && s_axi_awready &&
                 s_axi_awaddr[7:0] == 8'h18)
            idleCnt_q <= 16'h0000;
        else if (idleCnt_q != 16'hFFFF)
            idleCnt_q <= idleCnt_q + 16'h0001;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    wdog_low_a:
        assert property (idleCnt_q > WDOG_CYCLES + 8 |-> outPins == 4'h0)
        else $error("outputs active without cyclic writes");
    led_match_a:
        assert property (outLeds == outPins)
        else $error("output leds differ from outputs");
    reset_clear_a:
        assert property ($fell(reset) |-> outPins == 4'h0 &&
                         inLeds == 8'h00 && !irq)
        else $error("outputs not cleared by reset");
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                         s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=>
                         s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=>
                         s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    one_read_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
endmodule // mfio_slot_mux_properties

bind mfio_slot_mux mfio_slot_mux_properties #(.WDOG_CYCLES(WDOG_CYCLES))
    u_props (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .outPins(outPins), .inLeds(inLeds), .outLeds(outLeds), .irq(irq));

/* File: test/mfio_host_model.sv */
// host cpu model: axi4-lite master doing the cyclic exchanges
`timescale 1ns/1ps
module mfio_host_model
(
    input wire clk,
    output reg [31:0] awaddr = 32'h0,
    output reg awvalid = 1'b0,
    input wire awready,
    output reg [31:0] wdata = 32'h0,
    output reg wvalid = 1'b0,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    output reg bready = 1'b0,
    output reg [31:0] araddr = 32'h0,
    output reg arvalid = 1'b0,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    output reg rready = 1'b0
);
    // slow: ready held off until the answer shows
    reg slow = 1'b0;
    // one exchange at a time, each well inside the watchdog
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
        @(posedge clk);
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !slow;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid && !bready)
                bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    end
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
        @(posedge clk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= !slow;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid && !rready)
                rready <= 1'b1;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    end
    endtask
endmodule // mfio_host_model

/* File: test/test_mfio_slot_mux.sv */
// self-checking bench for the slot mux
`timescale 1ns/1ps
`include "mfio_map.vh"
module test_mfio_slot_mux;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg [7:0] inPins = 8'h00;
    reg [23:0] analogIn = 24'h000000;
    wire [31:0] awaddr, wdata, araddr, rdata;
    wire awvalid, awready, wvalid, wready, bvalid, bready;
    wire arvalid, arready, rvalid, rready, irq;
    wire [1:0] bresp, rresp;
    wire [3:0] outPins, outLeds;
    wire [7:0] inLeds;
    integer mismatches = 0;
    integer cmpCount = 0;
    reg [31:0] rv;
    reg [1:0] resp;
    always #4 clk = ~clk;
    // short watchdog keeps the expiry case quick
    mfio_slot_mux #(.WDOG_CYCLES(200)) u_dut (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .inPins(inPins), .analogIn(analogIn),
        .outPins(outPins), .inLeds(inLeds), .outLeds(outLeds), .irq(irq));
    mfio_host_model u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    // --------------------
    // helpers
    // --------------------
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        cmpCount = cmpCount + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        u_host.wr(a, d, resp);
    endtask
    task rd(input [7:0] a);
        u_host.rd(a, rv, resp);
    endtask
    task settle;
        repeat (3) @(negedge clk);
    endtask
    task hold(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task pins(input [7:0] v);
    begin
        @(posedge clk);
        inPins <= v;
        hold(3000);
    end
    endtask
    task tally_and_finish;
    begin
        if (mismatches == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // --------------------
    // scenarios
    // --------------------
    task t_reset;
    begin
        rd(`MFIO_REG_SLOTCFG);
        chk(rv, 32'h0);
        rd(`MFIO_REG_FILTSTD);
        chk(rv, 32'(`MFIO_FILT_DEF));
        rd(8'h40);
        chk(32'(resp), 32'h2);
        wr(8'h34, 32'h1);
        chk(32'(resp), 32'h2);
    end
    endtask
    task t_outputs;
    begin
        wr(`MFIO_REG_SLOTCFG, 32'h7);
        wr(`MFIO_REG_CYCLE, 32'h1);
        wr(`MFIO_REG_OUTSET, 32'hA);
        settle;
        chk(32'(outPins), 32'hA);
        chk(32'(outLeds), 32'hA);
    end
    endtask
    task t_pwm;
    begin
        u_host.slow = 1'b1;
        wr(`MFIO_REG_SLOTCFG, 32'hB);
        wr(`MFIO_REG_CYCLE, 32'h1);
        wr(`MFIO_REG_PWMDUTY3, 32'hFFFF);
        wr(`MFIO_REG_PWMDUTY4, 32'h0000);
        wr(`MFIO_REG_OUTSET, 32'h3);
        rd(`MFIO_REG_SLOTCFG);
        chk(rv, 32'hB);
        u_host.slow = 1'b0;
        repeat (8)
        begin
            settle;
            chk(32'(outPins), 32'h7);
        end
    end
    endtask
    task t_wdog;
    begin
        wr(`MFIO_REG_IRQSTAT, 32'h7);
        wr(`MFIO_REG_IRQMASK, 32'h1);
        wr(`MFIO_REG_CYCLE, 32'h1);
        hold(150);
        chk(32'(outPins), 32'h7);
        hold(100);
        chk(32'(outPins), 32'h0);
        chk(32'(irq), 32'h1);
        rd(`MFIO_REG_CYCLE);
        chk(rv & 32'h1, 32'h1);
        wr(`MFIO_REG_IRQMASK, 32'h0);
        settle;
        chk(32'(irq), 32'h0);
        wr(`MFIO_REG_CYCLE, 32'h1);
        wr(`MFIO_REG_IRQSTAT, 32'h1);
        settle;
        chk(32'(outPins), 32'h7);
        rd(`MFIO_REG_IRQSTAT);
        chk(rv & 32'h1, 32'h0);
    end
    endtask
    // inputs 3..6 take the fast extra filter, the rest the slow one
    task t_filter;
    begin
        wr(`MFIO_REG_SLOTCFG, 32'h23);
        wr(`MFIO_REG_FILTSTD, 32'd20);
        wr(`MFIO_REG_FILTEXT, 32'd1);
        pins(8'hFF);
        chk(32'(inLeds), 32'h3C);
        hold(25000);
        chk(32'(inLeds), 32'hFF);
        rd(`MFIO_REG_INSTATE);
        chk(rv & 32'hFF, 32'hFF);
        rd(`MFIO_REG_IRQSTAT);
        chk(rv & 32'h4, 32'h4);
    end
    endtask
    task t_counter;
    begin
        wr(`MFIO_REG_SLOTCFG, 32'h2);
        wr(`MFIO_REG_FILTSTD, 32'd1);
        pins(8'h02);
        wr(`MFIO_REG_COUNT, 32'h0);
        repeat (3)
        begin
            pins(8'h03);
            pins(8'h02);
        end
        rd(`MFIO_REG_COUNT);
        chk(rv, 32'h3);
        pins(8'h00);
        pins(8'h01);
        rd(`MFIO_REG_COUNT);
        chk(rv, 32'h2);
    end
    endtask
    // three forward encoder steps, then input 3 latches the count
    task t_encoder;
    begin
        wr(`MFIO_REG_SLOTCFG, 32'h11);
        wr(`MFIO_REG_COUNT, 32'h0);
        @(posedge clk);
        analogIn <= 24'hABC123;
        pins(8'h03);
        pins(8'h02);
        pins(8'h00);
        rd(`MFIO_REG_COUNT);
        chk(rv, 32'h3);
        pins(8'h04);
        rd(`MFIO_REG_LATCH);
        chk(rv, 32'h3);
        rd(`MFIO_REG_ANALOG);
        chk(rv, 32'h0ABC0123);
    end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_outputs;
        t_pwm;
        t_wdog;
        t_filter;
        t_counter;
        t_encoder;
        tally_and_finish;
    end
    initial
    begin
        #760000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // test_mfio_slot_mux
